//--- verilog/serializer_pkg.sv
// Shared constants and types for the eight-channel input serializer.
package serializer_pkg;
    localparam int NUM_CH = 8;
    // Debounce selections decoded from {debounce_sel_hi, debounce_sel_lo}, 1 = open.
    localparam logic [1:0] SEL_3MS = 2'h3;
    localparam logic [1:0] SEL_1MS = 2'h2;
    localparam logic [1:0] SEL_0MS = 2'h1;
    localparam logic [1:0] SEL_RSVD = 2'h0;
    // Times in microseconds and the core clock rate in MHz.
    localparam int T_DB1_US = 1000;
    localparam int T_DB3_US = 3000;
    localparam int CLK_MHZ = 250;
    localparam int CNT_1MS = T_DB1_US * CLK_MHZ;
    localparam int CNT_3MS = T_DB3_US * CLK_MHZ;
    localparam int CNT_W = 20;
    localparam int FIFO_DEPTH = 32;
    // Temperature thresholds in degrees.
    localparam logic [7:0] T_OVER_C = 8'h96;
    localparam logic [7:0] T_SHDN_C = 8'haa;

    typedef struct packed {
        logic load_n;
        logic ce_n;
        logic sin;
    } link_ctl_t;

    typedef enum logic [2:0] {
        ST_IDLE = 3'b001,
        ST_SHIFT = 3'b010,
        ST_SHDN = 3'b100
    } link_state_t;
endpackage

//--- verilog/snap_fifo.sv
// The snapshot FIFO module now lives beside the serializer in the serializer's design file.

//--- verilog/input_serializer.sv
// Eight-channel debounced input serializer with a chainable shift link.
// Summary of operation
// - Every field input passes a debounce filter before it can be captured.
// - Load strobe captures all states in parallel; clocks then shift them out.
// - Select pins choose bypass, 1 ms or 3 ms debounce.
// - Bypass setting lets inputs follow changes up to 1 Mbps.
// - Over-temperature fault flagged at 150 degrees.
// - At 170 degrees the device enters shutdown.
// - While load is low the register keeps loading parallel inputs.
// - Rising clock with load high, enable low shifts; enable high holds.
// - New level accepted only after stable for whole debounce time.
// - Temperature-ok is high normally, low once over threshold.
`timescale 1ns/10ps
module input_serializer
    import serializer_pkg::*;
#(
    parameter int NUM = serializer_pkg::NUM_CH,
    parameter int DB1_CYC = serializer_pkg::CNT_1MS,
    parameter int DB3_CYC = serializer_pkg::CNT_3MS
) (
    // Core clock and reset
    input wire logic ref_clk,
    input wire logic resetn,
    // Field side
    input wire logic [NUM-1:0] field_input_x,
    input wire logic debounce_sel_lo,
    input wire logic debounce_sel_hi,
    input wire logic [7:0] die_temp_c,
    // Serial link, clocked by the controller
    input wire logic link_clk,
    input wire logic capture_strobe_n,
    input wire logic clk_enable_n,
    input wire logic serial_in,
    output logic serial_out,
    output logic serial_out_oe,
    // Status
    output logic temp_ok_n,
    output logic temp_ok_oe
);
    import serializer_pkg::*;

    // ==========================================================
    // Input synchronisers and debounce
    // ==========================================================
    logic [NUM-1:0] s1_r, s2_r, s3_r, filt_r, filt_nxt;
    logic [1:0] sel_s1_r, sel_s2_r, sel_s3_r;
    logic [CNT_W-1:0] cnt_r [NUM];
    logic [CNT_W-1:0] cnt_nxt [NUM];
    logic [CNT_W-1:0] db_limit;
    logic [1:0] sel_r, sel_nxt;

    // A select change counts only once stages two and three agree.
    assign sel_nxt = (sel_s2_r == sel_s3_r) ? sel_s3_r : sel_r;

    always_comb begin
        if (sel_r == SEL_0MS) begin
            db_limit = '0;
        end else if (sel_r == SEL_1MS) begin
            db_limit = CNT_W'(DB1_CYC);
        end else begin
            db_limit = CNT_W'(DB3_CYC);
        end
    end

    always_comb begin
        filt_nxt = filt_r;
        for (int i = 0; i < NUM; i++) begin
            cnt_nxt[i] = '0;
            if (s2_r[i] != s3_r[i] || s3_r[i] == filt_r[i]) begin
                cnt_nxt[i] = '0;
            end else if (cnt_r[i] >= db_limit) begin
                filt_nxt[i] = s3_r[i];
            end else begin
                cnt_nxt[i] = cnt_r[i] + 1'b1;
            end
        end
    end

    always_ff @(posedge ref_clk) begin
        if (!resetn) begin
            s1_r <= '0;
            s2_r <= '0;
            s3_r <= '0;
            sel_s1_r <= '0;
            sel_s2_r <= '0;
            sel_s3_r <= '0;
            sel_r <= SEL_RSVD;
            filt_r <= '0;
            for (int i = 0; i < NUM; i++) begin
                cnt_r[i] <= '0;
            end
        end else begin
            s1_r <= field_input_x;
            s2_r <= s1_r;
            s3_r <= s2_r;
            sel_s1_r <= {debounce_sel_hi, debounce_sel_lo};
            sel_s2_r <= sel_s1_r;
            sel_s3_r <= sel_s2_r;
            sel_r <= sel_nxt;
            filt_r <= filt_nxt;
            for (int i = 0; i < NUM; i++) begin
                cnt_r[i] <= cnt_nxt[i];
            end
        end
    end

    // ==========================================================
    // Temperature supervision
    // ==========================================================
    logic over_r, over_nxt, shdn_r, shdn_nxt;

    always_comb begin
        over_nxt = (die_temp_c >= T_OVER_C);
        shdn_nxt = (die_temp_c >= T_SHDN_C);
    end

    always_ff @(posedge ref_clk) begin
        if (!resetn) begin
            over_r <= 1'b0;
            shdn_r <= 1'b0;
        end else begin
            over_r <= over_nxt;
            shdn_r <= shdn_nxt;
        end
    end

    // active low fault; the pin is released, not driven, in shutdown.
    assign temp_ok_n = !over_r;
    assign temp_ok_oe = !shdn_r;

    // ==========================================================
    // Snapshot FIFO and crossing to the link domain
    // ==========================================================
    // Snapshots stream into the FIFO every cycle it is not full; when it is full the oldest
    // entry is drained, so a full FIFO takes a new snapshot only every other cycle.
    logic f_in_ready, f_out_valid, f_pop;
    logic [NUM-1:0] f_out_data, snap_r, snap_nxt;
    logic [NUM-1:0] xfer_r, xfer_nxt;
    logic req_tgl_r, req_tgl_nxt, ack_s1_r, ack_s2_r, ack_s3_r;
    logic ack_tgl_r, ack_tgl_nxt;

    snap_fifo #(.WIDTH(NUM), .DEPTH(FIFO_DEPTH)) u_fifo (
        .clk(ref_clk),
        .resetn(resetn),
        .in_valid(1'b1),
        .in_ready(f_in_ready),
        .in_data(filt_r),
        .out_valid(f_out_valid),
        .out_ready(f_pop),
        .out_data(f_out_data)
    );

    // Drain when full or once the last word has been acknowledged, and hand words over
    // through a toggle handshake to the link domain.
    assign f_pop = f_out_valid && (!f_in_ready || (ack_s3_r == req_tgl_r));

    always_comb begin
        snap_nxt = f_pop ? f_out_data : snap_r;
        xfer_nxt = xfer_r;
        req_tgl_nxt = req_tgl_r;
        if (ack_s3_r == req_tgl_r && ack_s2_r == ack_s3_r) begin
            xfer_nxt = snap_r;
            req_tgl_nxt = !req_tgl_r;
        end
    end

    always_ff @(posedge ref_clk) begin
        if (!resetn) begin
            snap_r <= '0;
            xfer_r <= '0;
            req_tgl_r <= 1'b0;
            ack_s1_r <= 1'b0;
            ack_s2_r <= 1'b0;
            ack_s3_r <= 1'b0;
        end else begin
            snap_r <= snap_nxt;
            xfer_r <= xfer_nxt;
            req_tgl_r <= req_tgl_nxt;
            ack_s1_r <= ack_tgl_r;
            ack_s2_r <= ack_s1_r;
            ack_s3_r <= ack_s2_r;
        end
    end

    // ==========================================================
    // Link domain shift register
    // ==========================================================
    logic req_s1_r, req_s2_r, req_s3_r;
    logic [NUM-1:0] held_r, held_nxt, shift_r, shift_nxt;
    link_ctl_t ctl;

    assign ctl = '{load_n: capture_strobe_n, ce_n: clk_enable_n, sin: serial_in};

    always_comb begin
        held_nxt = held_r;
        ack_tgl_nxt = ack_tgl_r;
        if (req_s3_r != ack_tgl_r) begin
            held_nxt = xfer_r;
            ack_tgl_nxt = req_s3_r;
        end
        shift_nxt = shift_r;
        if (!ctl.load_n) begin
            shift_nxt = held_nxt;
        end else if (!ctl.ce_n) begin
            shift_nxt = {shift_r[NUM-2:0], ctl.sin};
        end
    end

    always_ff @(posedge link_clk) begin
        if (!resetn) begin
            req_s1_r <= 1'b0;
            req_s2_r <= 1'b0;
            req_s3_r <= 1'b0;
            ack_tgl_r <= 1'b0;
            held_r <= '0;
            shift_r <= '0;
        end else begin
            req_s1_r <= req_tgl_r;
            req_s2_r <= req_s1_r;
            req_s3_r <= req_s2_r;
            ack_tgl_r <= ack_tgl_nxt;
            held_r <= held_nxt;
            shift_r <= shift_nxt;
        end
    end

    assign serial_out = shift_r[NUM-1];
    // The serial clock stops between frames, so the output enable is taken
    // from the core domain; a link-side copy would never see shutdown.
    // outputs released in shutdown
    assign serial_out_oe = !shdn_r;
endmodule // input_serializer

// ==========================================================
// Snapshot FIFO
// ==========================================================
// Flip-flop storage keeps the depth small and the timing simple; a full
// FIFO refuses new words until one is drained.
module snap_fifo #(
    parameter int WIDTH = 8,
    parameter int DEPTH = 32
) (
    // Clock and reset
    input wire logic clk,
    input wire logic resetn,
    // Fill side
    input wire logic in_valid,
    output logic in_ready,
    input wire logic [WIDTH-1:0] in_data,
    // Drain side
    output logic out_valid,
    input wire logic out_ready,
    output logic [WIDTH-1:0] out_data
);
    localparam int AW = $clog2(DEPTH);
    logic [WIDTH-1:0] mem_r [DEPTH];
    logic [AW-1:0] wp_r, wp_nxt, rp_r, rp_nxt;
    logic [AW:0] cnt_r, cnt_nxt;
    logic push, pop;

    assign in_ready = (cnt_r != (AW+1)'(DEPTH));
    assign out_valid = (cnt_r != '0);
    assign out_data = mem_r[rp_r];
    assign push = in_valid && in_ready;
    assign pop = out_valid && out_ready;

    always_comb begin
        wp_nxt = push ? wp_r + 1'b1 : wp_r;
        rp_nxt = pop ? rp_r + 1'b1 : rp_r;
        cnt_nxt = cnt_r + (AW+1)'(push) - (AW+1)'(pop);
    end

    always_ff @(posedge clk) begin
        if (!resetn) begin
            wp_r <= '0;
            rp_r <= '0;
            cnt_r <= '0;
        end else begin
            wp_r <= wp_nxt;
            rp_r <= rp_nxt;
            cnt_r <= cnt_nxt;
        end
        if (push) begin
            mem_r[wp_r] <= in_data;
        end
    end
endmodule // snap_fifo

//--- bench/input_serializer_monitor.sv
// Pin-level checker for the input serializer.
`timescale 1ns/10ps
module input_serializer_monitor
    import serializer_pkg::*;
(
    // Clocks and reset
    input wire logic ref_clk,
    input wire logic link_clk,
    input wire logic resetn,
    // Watched pins
    input wire logic [7:0] die_temp_c,
    input wire logic capture_strobe_n,
    input wire logic clk_enable_n,
    input wire logic serial_in,
    input wire logic serial_out,
    input wire logic serial_out_oe,
    input wire logic temp_ok_n,
    input wire logic temp_ok_oe
);
    property p_tok_hi;
        @(posedge ref_clk) disable iff (!resetn) (die_temp_c < T_OVER_C) [*4] |-> temp_ok_n;
    endproperty
    a_tok_hi: assert property (p_tok_hi) else $error("temp ok not high");
    property p_tok_lo;
        @(posedge ref_clk) disable iff (!resetn) (die_temp_c >= T_OVER_C) [*4] |-> !temp_ok_n;
    endproperty
    a_tok_lo: assert property (p_tok_lo) else $error("temp ok not low");
    property p_sop_off;
        @(posedge ref_clk) disable iff (!resetn) (die_temp_c >= T_SHDN_C) [*4] |-> !serial_out_oe;
    endproperty
    a_sop_off: assert property (p_sop_off) else $error("serial out driven in shutdown");
    property p_tok_off;
        @(posedge ref_clk) disable iff (!resetn) (die_temp_c >= T_SHDN_C) [*4] |-> !temp_ok_oe;
    endproperty
    a_tok_off: assert property (p_tok_off) else $error("temp ok driven in shutdown");
    property p_sop_on;
        @(posedge ref_clk) disable iff (!resetn) (die_temp_c < T_SHDN_C) [*4] |-> serial_out_oe;
    endproperty
    a_sop_on: assert property (p_sop_on) else $error("serial out not driven");
    property p_tok_on;
        @(posedge ref_clk) disable iff (!resetn) (die_temp_c < T_SHDN_C) [*4] |-> temp_ok_oe;
    endproperty
    a_tok_on: assert property (p_tok_on) else $error("temp ok not driven");
    property p_shift;
        @(posedge link_clk) disable iff (!resetn) (capture_strobe_n && !clk_enable_n) [*8]
            |=> serial_out == $past(serial_in, 8);
    endproperty
    a_shift: assert property (p_shift) else $error("serial in not at output after 8 shifts");
    property p_hold;
        @(posedge link_clk) disable iff (!resetn) (capture_strobe_n && clk_enable_n)
            |=> $stable(serial_out);
    endproperty
    a_hold: assert property (p_hold) else $error("serial out moved while held");
endmodule // input_serializer_monitor

bind input_serializer input_serializer_monitor mon (.ref_clk, .link_clk, .resetn, .die_temp_c,
    .capture_strobe_n, .clk_enable_n, .serial_in, .serial_out, .serial_out_oe, .temp_ok_n,
    .temp_ok_oe);

//--- bench/link_host.sv
// Controller-side model of the serial link.
`timescale 1ns/10ps
module link_host (
    // Link pins
    output logic link_clk,
    output logic capture_strobe_n,
    output logic clk_enable_n,
    output logic serial_in,
    input wire logic serial_out
);
    initial begin
        link_clk = 1'b0;
        capture_strobe_n = 1'b1;
        clk_enable_n = 1'b1;
        serial_in = 1'b0;
    end
    // The clock only runs inside calls, as a real controller's does.
    task automatic pulse();
        #7.5 link_clk = 1'b1;
        #7.5 link_clk = 1'b0;
    endtask
    task automatic frame(input int n, input logic [15:0] feed, output logic [15:0] got);
        got = 16'h0;
        capture_strobe_n = 1'b0;
        clk_enable_n = 1'b0;
        // The snapshot crosses on link edges only, so the load is held long
        // enough for a fresh word to arrive after an idle clock.
        repeat (8) pulse();
        capture_strobe_n = 1'b1;
        for (int i = n - 1; i >= 0; i--) begin
            got[i] = serial_out;
            serial_in = feed[i + 16 - n];
            if (i == 3) begin
                clk_enable_n = 1'b1;
                pulse();
                clk_enable_n = 1'b0;
            end
            pulse();
        end
        clk_enable_n = 1'b1;
    endtask
endmodule // link_host

//--- bench/input_serializer_test.sv
// Self-checking bench for the input serializer.
`timescale 1ns/10ps
module input_serializer_test;
    import serializer_pkg::*;
    logic ref_clk = 1'b0;
    logic resetn = 1'b0;
    logic [7:0] field_input_x = 8'h00;
    logic debounce_sel_lo = 1'b1;
    logic debounce_sel_hi = 1'b0;
    logic [7:0] die_temp_c = 8'h19;
    logic link_clk, capture_strobe_n, clk_enable_n, serial_in, serial_out, serial_out_oe;
    logic temp_ok_n, temp_ok_oe;
    logic [15:0] got;
    int miscompares = 0;
    int check_count = 0;
    always #2 ref_clk = ~ref_clk;
    input_serializer #(.DB1_CYC(20), .DB3_CYC(60)) DUT (.ref_clk, .resetn, .field_input_x,
        .debounce_sel_lo, .debounce_sel_hi, .die_temp_c, .link_clk, .capture_strobe_n,
        .clk_enable_n, .serial_in, .serial_out, .serial_out_oe, .temp_ok_n, .temp_ok_oe);
    link_host host (.link_clk, .capture_strobe_n, .clk_enable_n, .serial_in, .serial_out);
    task automatic tick(input int n);
        repeat (n) @(posedge ref_clk);
        #1;
    endtask
    task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] seen);
        check_count++;
        if (seen !== exp) begin
            miscompares++;
            $display("[ERR] %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic test_done();
        $display("Checks %0d, mismatches %0d", check_count, miscompares);
        if (miscompares == 0 && check_count > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask
    // Bypass, changes about once a microsecond, read as 16 bits with the host feed standing in for a second device.
    task automatic t_bypass();
        logic [7:0] v;
        debounce_sel_lo = 1'b1;
        debounce_sel_hi = 1'b0;
        for (int k = 0; k < 3; k++) begin
            v = k[0] ? 8'h5a : 8'ha5;
            field_input_x = v;
            tick(210);
            host.frame(16, 16'h3c00, got);
            chk("chain", {v, 8'h3c}, got);
        end
    endtask
    // A pulse shorter than the filter must never be read; a steady level must.
    task automatic t_filter(input logic lo, input logic hi, input int db);
        debounce_sel_lo = lo;
        debounce_sel_hi = hi;
        field_input_x = 8'h0f;
        tick(db + 200);
        field_input_x = 8'hf0;
        tick(db * 3 / 4);
        field_input_x = 8'h0f;
        for (int k = 0; k < 5; k++) begin
            host.frame(8, 16'h0, got);
            chk("short pulse", 16'h000f, got);
        end
        field_input_x = 8'hf0;
        tick(db + 200);
        host.frame(8, 16'h0, got);
        chk("settled", 16'h00f0, got);
    endtask
    task automatic t_temp();
        logic [7:0] t [5] = '{8'h95, 8'h96, 8'ha9, 8'haa, 8'h19};
        for (int k = 0; k < 5; k++) begin
            die_temp_c = t[k];
            tick(10);
            chk("temp pins", {13'h0, t[k] < T_SHDN_C, t[k] < T_SHDN_C, t[k] < T_OVER_C},
                {13'h0, serial_out_oe, temp_ok_oe, temp_ok_oe & temp_ok_n});
        end
    endtask
    initial begin
        fork
            tick(5);
            repeat (4) host.pulse();
        join
        tick(1);
        resetn = 1'b1;
        tick(4);
        t_bypass();
        t_filter(1'b0, 1'b1, 20);
        t_filter(1'b1, 1'b1, 60);
        t_filter(1'b0, 1'b0, 60);
        t_temp();
        test_done();
    end
    initial begin
        #100000;
        miscompares++;
        test_done();
    end
endmodule // input_serializer_test
